/* File: hw/cvr_pkg.sv */
// Constants shared by the cell voltage result logic.
// Assumes a single 200 MHz core clock and ADC results in 78.125 uV cell steps.

package cvr_pkg;
  // ----------------------------------------------------------------
  // Register offsets (register port index)
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_LOWEST = 9'h009;
  localparam logic [8:0] ADDR_AVG_LOWEST = 9'h019;
  localparam logic [8:0] ADDR_EXTREMES = 9'h01b;
  localparam logic [8:0] ADDR_AVG_CELL_VOLTAGE_FOURTH = 9'h0d1;
  localparam logic [8:0] ADDR_AVG_CELL_VOLTAGE_THIRD = 9'h0d2;
  localparam logic [8:0] ADDR_AVG_CELL_VOLTAGE_SECOND = 9'h0d3;
  localparam logic [8:0] ADDR_AVG_CELL_VOLTAGE_FIRST = 9'h0d4;
  localparam logic [8:0] ADDR_CELL_VOLTAGE_FOURTH = 9'h0d5;
  localparam logic [8:0] ADDR_CELL_VOLTAGE_THIRD = 9'h0d6;
  localparam logic [8:0] ADDR_CELL_VOLTAGE_SECOND = 9'h0d7;
  localparam logic [8:0] ADDR_CELL_VOLTAGE_FIRST = 9'h0d8;
  localparam logic [8:0] ADDR_TAP = 9'h0d9;
  localparam logic [8:0] ADDR_STACK = 9'h0da;
  localparam logic [8:0] ADDR_EXTREMES_BACKUP = 9'h1ac;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EXTREMES_RESET = 16'h00ff;
  localparam int EXT_HI_POS = 8;
  localparam logic [3:0] AVG_CELL_SHIFT = 4'h3;
  localparam int STACK_SHIFT = 4;
  localparam logic [3:0] HIB_SCALER_BASE = 4'h7;
  // ----------------------------------------------------------------
  // Channel codes, in measuring order
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_TAP = 3'h0;
  localparam logic [2:0] CH_C1 = 3'h1;
  localparam logic [2:0] CH_C2 = 3'h2;
  localparam logic [2:0] CH_C3 = 3'h3;
  localparam logic [2:0] CH_STACK = 3'h4;
  localparam int NUM_CH = 5;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int TASK_PERIOD_MS = 351;
  localparam int TASK_CYCLES = TASK_PERIOD_MS * CLK_KHZ;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_POST} seq_state_e;
endpackage

/* File: hw/avg_if.sv */
// Sample and result bundle of one averaging filter.
// Assumes all signals belong to the core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface avg_if;
  logic valid;
  logic [15:0] sample;
  logic [3:0] shift;
  logic restart;
  logic [15:0] avg;
  modport filt (input valid, input sample, input shift, input restart, output avg);
  modport user (output valid, output sample, output shift, output restart, input avg);
endinterface
`default_nettype wire

/* File: hw/avg_filter.sv */
// Exponential averaging filter seeded by its first sample.
// Assumes synchronised active-low reset and same-clock inputs.
`timescale 1ns/1ps
`default_nettype none
module avg_filter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Filter bundle
  avg_if.filt bus
);
  logic seeded_r;
  logic [15:0] avg_r;
  logic signed [16:0] diff;
  logic signed [16:0] step;
  logic [15:0] avg_nxt;

  // Step toward the sample; arithmetic shift keeps the sign
  assign diff = $signed({1'b0, bus.sample}) - $signed({1'b0, avg_r});
  assign step = diff >>> bus.shift;
  assign avg_nxt = seeded_r ? 16'(avg_r + step[15:0]) : bus.sample;
  assign bus.avg = avg_r;

  // Restart drops the seed so the next sample is taken whole
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seeded_r <= 1'b0;
      avg_r <= 16'h0000;
    end
    else if (bus.restart)
      seeded_r <= 1'b0;
    else if (bus.valid)
    begin
      seeded_r <= 1'b1;
      avg_r <= avg_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: hw/cell_voltage_result_regs.sv */
// Cell voltage post-processing and result registers.
// Assumes ADC, config bits and strobes come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cell_voltage_result_regs #(
  parameter int TASK_CYCLES = cvr_pkg::TASK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // ADC request and result
  output logic adc_req,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [15:0] adc_result,
  // Pack configuration
  input wire logic per_channel_enable,
  input wire logic divided_tap_enable,
  input wire logic stack_measure_enable,
  input wire logic [3:0] series_cell_count,
  // Averaging and modes
  input wire logic [3:0] averaging_filter_config,
  input wire logic [3:0] relaxation_config,
  input wire logic relax_detected,
  input wire logic current_detected,
  input wire logic shutdown,
  input wire logic hibernate,
  input wire logic [3:0] hibernate_scaler,
  // Extremes backup
  input wire logic extremes_backup_enable,
  input wire logic backup_tick
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic ch_enabled(input logic [2:0] ch, input logic pce, input logic dte,
                                      input logic sme, input logic [3:0] n);
    logic en;
    en = 1'b0;
    case (ch)
      cvr_pkg::CH_TAP: en = dte;
      cvr_pkg::CH_C1: en = pce;
      cvr_pkg::CH_C2: en = pce && (n >= 4'h2);
      cvr_pkg::CH_C3: en = pce && (n >= 4'h3);
      cvr_pkg::CH_STACK: en = sme && !pce && !dte;
      default: en = 1'b0;
    endcase
    return en;
  endfunction

  function automatic logic [2:0] wrap_inc(input logic [2:0] ch);
    return (ch == cvr_pkg::CH_STACK) ? cvr_pkg::CH_TAP : 3'(ch + 3'h1);
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // Release through two flops to avoid a ragged reset exit
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Task timer and hibernate scaling
  // ----------------------------------------------------------------
  logic [31:0] task_cnt_r;
  logic [15:0] hib_cnt_r;
  logic task_tick;
  logic [15:0] hib_periods;
  logic go;

  assign task_tick = (task_cnt_r == 32'(TASK_CYCLES - 1));
  // Below the base the scaler means one period per update
  assign hib_periods = (hibernate_scaler > cvr_pkg::HIB_SCALER_BASE) ?
                       16'(16'h0001 << (hibernate_scaler - cvr_pkg::HIB_SCALER_BASE)) : 16'h0001;
  assign go = task_tick && (!hibernate || (hib_cnt_r >= 16'(hib_periods - 16'h0001)));

  // Free-running period counter; hibernate skips whole periods
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      task_cnt_r <= 32'h0000_0000;
      hib_cnt_r <= 16'h0000;
    end
    else
    begin
      task_cnt_r <= task_tick ? 32'h0000_0000 : 32'(task_cnt_r + 32'h1);
      if (go || !hibernate)
        hib_cnt_r <= 16'h0000;
      else if (task_tick)
        hib_cnt_r <= 16'(hib_cnt_r + 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // Channel sequencer
  // ----------------------------------------------------------------
  cvr_pkg::seq_state_e state_r;
  logic [2:0] chan_r;
  logic [2:0] next_chan;
  logic [2:0] after_chan;
  logic any_en;
  logic pass_end;

  // Scan forward at most one lap for the next enabled channel
  always_comb
  begin
    logic [2:0] c;
    c = chan_r;
    next_chan = chan_r;
    for (int i = 0; i < cvr_pkg::NUM_CH; i++)
    begin
      c = wrap_inc(c);
      if (ch_enabled(c, per_channel_enable, divided_tap_enable, stack_measure_enable, series_cell_count)
          && (next_chan == chan_r))
        next_chan = c;
    end
  end

  assign any_en = divided_tap_enable || per_channel_enable || stack_measure_enable;
  // The pass ends when the following enabled channel wraps back in order
  assign after_chan = next_chan;
  assign pass_end = (after_chan <= chan_r);
  assign adc_req = (state_r == cvr_pkg::ST_REQ);
  assign adc_chan = chan_r;

  // One request per go pulse (every task period unless hibernate skips it), each channel in fixed order
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= cvr_pkg::ST_IDLE;
      chan_r <= cvr_pkg::CH_STACK;
    end
    else
    begin
      case (state_r)
        cvr_pkg::ST_IDLE:
          if (go && any_en)
          begin
            chan_r <= next_chan;
            state_r <= cvr_pkg::ST_REQ;
          end
        cvr_pkg::ST_REQ: state_r <= cvr_pkg::ST_WAIT;
        cvr_pkg::ST_WAIT:
          if (adc_done)
            state_r <= pass_end ? cvr_pkg::ST_POST : cvr_pkg::ST_IDLE;
        cvr_pkg::ST_POST: state_r <= cvr_pkg::ST_IDLE;
        default: state_r <= cvr_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel results
  // ----------------------------------------------------------------
  logic [15:0] cell_r [4];
  logic [15:0] tap_r;
  logic [15:0] stack_r;
  logic store;
  logic post;
  logic [15:0] tap_val;
  logic [19:0] stack_div;
  logic [15:0] stack_per_cell;
  logic [19:0] tap_times_n;
  logic [17:0] cell_sum;
  logic [3:0] cell_we;
  logic [15:0] cell_wval;

  assign store = (state_r == cvr_pkg::ST_WAIT) && adc_done;
  assign post = (state_r == cvr_pkg::ST_POST);
  assign tap_val = {adc_result[14:0], 1'b0};
  // Division by count, guarded against a zero count; quotient truncates
  assign stack_div = (series_cell_count == 4'h0) ? 20'h00000 :
                     20'({adc_result, 4'h0} / series_cell_count);
  assign stack_per_cell = stack_div[15:0];
  // Widen before the product so the top bits of a large count are kept
  assign tap_times_n = 20'(tap_val) * 20'(series_cell_count);
  assign cell_sum = 18'(cell_r[0]) + 18'(cell_r[1]) + 18'(cell_r[2]);

  // Cell writes: one per measured cell, or all four in derived modes
  assign cell_we[0] = store && (chan_r == cvr_pkg::CH_C1 || chan_r == cvr_pkg::CH_TAP
                      || chan_r == cvr_pkg::CH_STACK);
  assign cell_we[1] = store && (chan_r == cvr_pkg::CH_C2 || chan_r == cvr_pkg::CH_TAP
                      || chan_r == cvr_pkg::CH_STACK);
  assign cell_we[2] = store && (chan_r == cvr_pkg::CH_C3 || chan_r == cvr_pkg::CH_TAP
                      || chan_r == cvr_pkg::CH_STACK);
  assign cell_we[3] = store && (chan_r == cvr_pkg::CH_TAP || chan_r == cvr_pkg::CH_STACK);
  assign cell_wval = (chan_r == cvr_pkg::CH_TAP) ? tap_val :
                     (chan_r == cvr_pkg::CH_STACK) ? stack_per_cell : adc_result;

  // Cell registers load directly from the selected value
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        cell_r[i] <= 16'h0000;
    else
      for (int i = 0; i < 4; i++)
        if (cell_we[i])
          cell_r[i] <= cell_wval;
  end

  // Tap and stack; stack in 1.25 mV steps, 16 cell steps each
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tap_r <= 16'h0000;
      stack_r <= 16'h0000;
    end
    else if (store && chan_r == cvr_pkg::CH_TAP)
    begin
      tap_r <= tap_val;
      stack_r <= tap_times_n[19:cvr_pkg::STACK_SHIFT];
    end
    else if (store && chan_r == cvr_pkg::CH_STACK)
      stack_r <= adc_result;
    else if (post && per_channel_enable)
      stack_r <= cell_sum[17:2] >> 2;
  end

  // ----------------------------------------------------------------
  // Lowest cell and extremes
  // ----------------------------------------------------------------
  logic [15:0] lowest_r;
  logic [15:0] min12;
  logic [15:0] lowest_calc;
  logic [15:0] ext_r;
  logic [15:0] ext_backup_r;
  logic [15:0] ext_base;
  logic [7:0] ext_sample;
  logic ext_wr;
  logic backup_evt;

  // Only cells that were measured take part in the minimum
  assign min12 = (per_channel_enable && series_cell_count >= 4'h2 && cell_r[1] < cell_r[0]) ?
                 cell_r[1] : cell_r[0];
  assign lowest_calc = (per_channel_enable && series_cell_count >= 4'h3 && cell_r[2] < min12) ?
                       cell_r[2] : min12;
  assign ext_wr = reg_wr && (reg_addr == cvr_pkg::ADDR_EXTREMES);
  assign backup_evt = backup_tick && extremes_backup_enable;
  // Backup restarts the segment, then a software write, then the held value
  assign ext_base = backup_evt ? cvr_pkg::EXTREMES_RESET : ext_wr ? reg_wdata : ext_r;
  assign ext_sample = lowest_calc[15:cvr_pkg::EXT_HI_POS];

  // Compare on top of any write so an update is never lost
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowest_r <= 16'h0000;
      ext_r <= cvr_pkg::EXTREMES_RESET;
      ext_backup_r <= 16'h0000;
    end
    else
    begin
      if (post)
        lowest_r <= lowest_calc;
      if (backup_evt)
        ext_backup_r <= ext_r;
      else if (reg_wr && reg_addr == cvr_pkg::ADDR_EXTREMES_BACKUP)
        ext_backup_r <= reg_wdata;
      ext_r[15:8] <= (post && ext_sample > ext_base[15:8]) ? ext_sample : ext_base[15:8];
      ext_r[7:0] <= (post && ext_sample < ext_base[7:0]) ? ext_sample : ext_base[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Averaging
  // ----------------------------------------------------------------
  logic relax_r;

  // Relaxation holds until current flows again; detection wins a tie
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      relax_r <= 1'b0;
    else if (relax_detected)
      relax_r <= 1'b1;
    else if (current_detected)
      relax_r <= 1'b0;
  end

  avg_if avg_bus [5] ();

  // Four cell filters plus the lowest-cell filter at index four
  for (genvar g = 0; g < 5; g++)
  begin : g_avg
    if (g < 4)
    begin : g_cell
      assign avg_bus[g].valid = cell_we[g];
      assign avg_bus[g].sample = cell_wval;
      assign avg_bus[g].shift = cvr_pkg::AVG_CELL_SHIFT;
    end
    else
    begin : g_low
      assign avg_bus[g].valid = post;
      assign avg_bus[g].sample = lowest_calc;
      assign avg_bus[g].shift = relax_r ? relaxation_config : averaging_filter_config;
    end
    assign avg_bus[g].restart = shutdown;
    avg_filter u_avg (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .bus(avg_bus[g])
    );
  end

  logic [15:0] avg_cell [4];
  logic [15:0] avg_lowest;
  assign avg_cell[0] = avg_bus[0].avg;
  assign avg_cell[1] = avg_bus[1].avg;
  assign avg_cell[2] = avg_bus[2].avg;
  assign avg_cell[3] = avg_bus[3].avg;
  assign avg_lowest = avg_bus[4].avg;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  // Unmapped offsets read zero
  assign rd_mux = (reg_addr == cvr_pkg::ADDR_LOWEST) ? lowest_r :
                  (reg_addr == cvr_pkg::ADDR_AVG_LOWEST) ? avg_lowest :
                  (reg_addr == cvr_pkg::ADDR_EXTREMES) ? ext_r :
                  (reg_addr == cvr_pkg::ADDR_AVG_CELL_VOLTAGE_FOURTH) ? avg_cell[3] :
                  (reg_addr == cvr_pkg::ADDR_AVG_CELL_VOLTAGE_THIRD) ? avg_cell[2] :
                  (reg_addr == cvr_pkg::ADDR_AVG_CELL_VOLTAGE_SECOND) ? avg_cell[1] :
                  (reg_addr == cvr_pkg::ADDR_AVG_CELL_VOLTAGE_FIRST) ? avg_cell[0] :
                  (reg_addr == cvr_pkg::ADDR_CELL_VOLTAGE_FOURTH) ? cell_r[3] :
                  (reg_addr == cvr_pkg::ADDR_CELL_VOLTAGE_THIRD) ? cell_r[2] :
                  (reg_addr == cvr_pkg::ADDR_CELL_VOLTAGE_SECOND) ? cell_r[1] :
                  (reg_addr == cvr_pkg::ADDR_CELL_VOLTAGE_FIRST) ? cell_r[0] :
                  (reg_addr == cvr_pkg::ADDR_TAP) ? tap_r :
                  (reg_addr == cvr_pkg::ADDR_STACK) ? stack_r :
                  (reg_addr == cvr_pkg::ADDR_EXTREMES_BACKUP) ? ext_backup_r : 16'h0000;

  // Read data is held until the next read
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [2:0] last_chan_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_chan_r <= cvr_pkg::CH_STACK;
    else if (adc_req)
      last_chan_r <= adc_chan;
  end

  AST_ONE_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    adc_req |=> !adc_req [*2])
    else $error("second request too soon");
  AST_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
    adc_req && adc_chan == cvr_pkg::CH_C2 && $stable(per_channel_enable) |-> last_chan_r == cvr_pkg::CH_C1)
    else $error("cell two not after cell one");
  AST_LOWEST: assert property (@(posedge core_clk) disable iff (!rst_n)
    post |=> lowest_r <= $past(cell_r[0]))
    else $error("lowest above first cell");
  AST_HIGH_MONO: assert property (@(posedge core_clk) disable iff (!rst_n)
    post && !backup_evt && !ext_wr |=> ext_r[15:8] >= $past(ext_r[15:8]) && ext_r[7:0] <= $past(ext_r[7:0]))
    else $error("extreme moved the wrong way");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_wr && reg_wdata == cvr_pkg::EXTREMES_RESET && !post && !backup_evt |=> ext_r == cvr_pkg::EXTREMES_RESET)
    else $error("clear write not applied");
  AST_BACKUP: assert property (@(posedge core_clk) disable iff (!rst_n)
    backup_evt && !post |=> ext_backup_r == $past(ext_r) && ext_r == cvr_pkg::EXTREMES_RESET)
    else $error("backup save or reset missing");
  AST_TAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    store && chan_r == cvr_pkg::CH_TAP |=> tap_r == {$past(adc_result[14:0]), 1'b0} && cell_r[3] == tap_r)
    else $error("tap value wrong");
  AST_STACK_SUM: assert property (@(posedge core_clk) disable iff (!rst_n)
    post && per_channel_enable |=> stack_r == 16'($past(cell_sum) >> cvr_pkg::STACK_SHIFT))
    else $error("stack sum wrong");
  AST_REQ_AFTER_GO: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(adc_req) |-> $past(go))
    else $error("request without task period");
  AST_CELL_AVG: assert property (@(posedge core_clk) disable iff (!rst_n)
    cell_we[0] && !shutdown |=> ##1 1'b1 ##0 (avg_cell[0] != 16'h0000 || $past(cell_wval, 2) == 16'h0000
    || $past(avg_cell[0], 2) != 16'h0000))
    else $error("cell average not loaded");

  COV_PASS3: cover property (@(posedge core_clk) disable iff (!rst_n) post && series_cell_count == 4'h3);
  COV_BACKUP: cover property (@(posedge core_clk) disable iff (!rst_n) backup_evt);
  COV_STACK: cover property (@(posedge core_clk) disable iff (!rst_n) store && chan_r == cvr_pkg::CH_STACK);
endmodule
`default_nettype wire

/* File: dv/cell_voltage_result_regs_tb_top.sv */
// Self-checking bench for the cell voltage result registers.
// Assumes cvr_pkg is compiled first; the bench itself plays the ADC.
`timescale 1ns/1ps
`default_nettype none
module cell_voltage_result_regs_tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, adc_done = 1'b0, adc_req, pce = 1'b1, dte = 1'b0, sme = 1'b0;
  logic shutdown = 1'b0, bk_en = 1'b0, bk_tick = 1'b0, en_adc = 1'b1, pend = 1'b0, hib = 1'b0;
  logic ans;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, adc_result = 16'h0000, lo, nlo, t;
  logic [15:0] tbl [0:4];
  logic [2:0] adc_chan, ch = 3'h0;
  logic [3:0] cnt = 4'h3, afc = 4'h4, dly = 4'h0;
  int n_mismatch = 0, total_checks = 0, n_done = 0, seed = 32'hbb43926c;
  localparam int TASK = 20;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Short task period keeps a pass within a hundred cycles
  cell_voltage_result_regs #(.TASK_CYCLES(TASK)) u_cell_voltage_result_regs (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_req(adc_req), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_result(adc_result), .per_channel_enable(pce), .divided_tap_enable(dte),
    .stack_measure_enable(sme), .series_cell_count(cnt), .averaging_filter_config(afc),
    .relaxation_config(4'h2), .relax_detected(1'b0), .current_detected(1'b0), .shutdown(shutdown),
    .hibernate(hib), .hibernate_scaler(4'hb), .extremes_backup_enable(bk_en), .backup_tick(bk_tick));

  // ADC stand-in: answers late; result line toggles while invalid so stale data is not reused
  assign ans = pend && en_adc && dly == 4'h0 && !adc_req;
  always @(posedge core_clk)
  begin
    adc_done <= ans;
    adc_result <= ans ? tbl[ch] : ~adc_result;
    if (adc_req)
    begin
      pend <= 1'b1;
      ch <= adc_chan;
      dly <= 4'h3;
    end
    else if (ans)
    begin
      pend <= 1'b0;
      n_done <= n_done + 1;
    end
    else if (pend && en_adc)
      dly <= dly - 4'h1;
  end

  function automatic logic [15:0] f_min3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    f_min3 = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
  endfunction
  function automatic logic [15:0] f_div(input logic [15:0] s, input logic [3:0] n);
    f_div = (n == 4'h0) ? 16'h0000 : 16'((20'(s) << 4) / n);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    total_checks++;
    if (reg_rdata !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t addr %h read %h expected %h", $time, a, reg_rdata, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Bounded wait for seven ADC answers, enough for two full passes
  task automatic passes;
    int target;
    target = n_done + 7;
    for (int i = 0; i < 3000 && n_done < target; i++)
      @(posedge core_clk);
    if (n_done < target)
    begin
      n_mismatch++;
      $display("ERROR %0t ADC traffic stalled", $time);
      stop_test();
    end
    else
      repeat (4) @(posedge core_clk);
  endtask
  // Cycles between two answers, measured once two more have passed
  task automatic chk_gap(input int exp);
    int base;
    int gap;
    base = n_done + 2;
    gap = 0;
    for (int i = 0; i < 3000 && n_done < base; i++)
      @(posedge core_clk);
    while (gap < 3000 && n_done == base)
    begin
      @(posedge core_clk);
      gap++;
    end
    total_checks++;
    if (gap != exp)
    begin
      n_mismatch++;
      $display("ERROR %0t answer gap %0d expected %0d", $time, gap, exp);
      if (gap >= 3000 || n_done < base)
        stop_test();
    end
  endtask
  task automatic mode(input logic p, input logic x, input logic s);
    en_adc <= 1'b0;
    repeat (8) @(posedge core_clk);
    pce <= p;
    dte <= x;
    sme <= s;
    shutdown <= 1'b1;
    @(posedge core_clk);
    shutdown <= 1'b0;
    en_adc <= 1'b1;
    passes();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 1; i < 4; i++)
      tbl[i] = 16'h2000 + (16'($random(seed)) & 16'h2fff);
    tbl[0] = 16'($random(seed)) & 16'h0fff;
    tbl[4] = 16'($random(seed)) & 16'h07ff;
    afc <= 4'($random(seed));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(cvr_pkg::ADDR_EXTREMES, 16'h00ff);
    rd(cvr_pkg::ADDR_LOWEST, 16'h0000);
    rd(9'h100, 16'h0000);
    $display("test reset done");
    passes();
    lo = f_min3(tbl[1], tbl[2], tbl[3]);
    for (int i = 0; i < 3; i++)
    begin
      rd(cvr_pkg::ADDR_CELL_VOLTAGE_FIRST - 9'(i), tbl[i + 1]);
      rd(cvr_pkg::ADDR_AVG_CELL_VOLTAGE_FIRST - 9'(i), tbl[i + 1]);
    end
    rd(cvr_pkg::ADDR_LOWEST, lo);
    rd(cvr_pkg::ADDR_AVG_LOWEST, lo);
    rd(cvr_pkg::ADDR_STACK, 16'((18'(tbl[1]) + tbl[2] + tbl[3]) >> 4));
    tbl[2] = lo - 16'h1000;
    passes();
    nlo = tbl[2];
    rd(cvr_pkg::ADDR_LOWEST, nlo);
    rd(cvr_pkg::ADDR_EXTREMES, {lo[15:8], nlo[15:8]});
    $display("test per_channel done");
    // Extremes backup, clear by write, read-only write ignored
    en_adc <= 1'b0;
    repeat (8) @(posedge core_clk);
    bk_en <= 1'b1;
    bk_tick <= 1'b1;
    @(posedge core_clk);
    bk_tick <= 1'b0;
    rd(cvr_pkg::ADDR_EXTREMES_BACKUP, {lo[15:8], nlo[15:8]});
    rd(cvr_pkg::ADDR_EXTREMES, 16'h00ff);
    wr(cvr_pkg::ADDR_EXTREMES, 16'h1234);
    wr(cvr_pkg::ADDR_EXTREMES, 16'h00ff);
    rd(cvr_pkg::ADDR_EXTREMES, 16'h00ff);
    wr(cvr_pkg::ADDR_LOWEST, 16'hffff);
    rd(cvr_pkg::ADDR_LOWEST, nlo);
    en_adc <= 1'b1;
    passes();
    rd(cvr_pkg::ADDR_EXTREMES, {nlo[15:8], nlo[15:8]});
    $display("test extremes done");
    cnt <= 4'h1 + 4'($random(seed) & 3);
    mode(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
      rd(cvr_pkg::ADDR_CELL_VOLTAGE_FIRST - 9'(i), f_div(tbl[4], cnt));
    rd(cvr_pkg::ADDR_STACK, tbl[4]);
    $display("test stack_mode done");
    mode(1'b0, 1'b1, 1'b0);
    t = {tbl[0][14:0], 1'b0};
    rd(cvr_pkg::ADDR_TAP, t);
    for (int i = 0; i < 4; i++)
      rd(cvr_pkg::ADDR_CELL_VOLTAGE_FIRST - 9'(i), t);
    rd(cvr_pkg::ADDR_STACK, 16'((20'(t) * cnt) >> 4));
    $display("test tap_mode done");
    // One channel per period when active; scaler 0xB stretches it to sixteen periods
    chk_gap(TASK);
    hib <= 1'b1;
    chk_gap(16 * TASK);
    $display("test hibernate done");
    stop_test();
  end
endmodule
`default_nettype wire
